// ---- logic/sar_adc_cfg.svh ----
// Register indices, field positions, reset values and widths for the converter control
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH
// Register indices; byte address is four times the index
`define CFG_IDX 8'hA9
`define LOW_IDX 8'hBA
`define HIGH_IDX 8'hBB
`define CTL_IDX 8'hCE
`define STAT_IDX 8'hD0
`define MASK_IDX 8'hD1
// converter_config fields
`define CFG_EN_BIT 7
`define CFG_IRQ_BIT 6
`define CFG_JUST_BIT 5
`define CFG_PRE_LSB 0
// converter_control fields
`define CTL_AVG_LSB 6
`define CTL_SEL_LSB 4
`define CTL_FLAG_BIT 1
`define CTL_START_BIT 0
// Reset values, then result and sum widths
`define CFG_RST 8'h00
`define CTL_RST 8'h00
`define MASK_RST 8'h00
`define RES_W 11
`define SUM_W 14
`endif

// ---- logic/sar_adc_control.sv ----
// APB-facing control, averaging and result logic of the 11-bit SAR converter
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
// ==========================================================
// Behaviour
// - Each conversion yields an 11-bit result for the selected input.
// - Completion raises an interrupt only while the irq enable bit is one.
// - Justify one: high 7..0 plus low 3..1; zero: high 2..0 plus low 7..0.
// - Prescale 0..7 divides system clock by 2 up to 256.
// - Averaging field picks 1, 2, 4 or 8 samples; resets to 00.
// - With several channels each one is averaged in turn; this block averages only the single selected input.
// - Select 00 ext a, 01 ext b, 10 temperature, 11 supply fifth.
// - Done flag sets once both result bytes hold the new value; not writable.
// - Reading the low result byte clears the done flag.
// - Result bytes are not overwritten while the done flag stands.
// - Writing start one while conv enable is one launches a conversion; hardware clears it when done.
// - Result bytes are read-only; writes leave them unchanged.
`include "sar_adc_cfg.svh"
module sar_adc_control #(
   parameter int RES_W = `RES_W
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [9:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_core_done,
   input wire logic [RES_W-1:0] i_core_data,
   output logic o_conv_enable,
   output logic o_core_clk,
   output logic o_core_start,
   output logic [1:0] o_input_select,
   output logic o_irq
);
   // ==========================================================
   // Registers
   sar_adc_pkg::conv_cfg_t cfg_q;
   sar_adc_pkg::conv_ctl_t ctl_q;
   sar_adc_pkg::seq_state_t state_q;
   logic start_q;
   logic flag_q;
   logic [RES_W-1:0] result_q;
   logic [`SUM_W-1:0] sum_q;
   logic [3:0] taken_q;
   logic status_q;
   logic mask_q;
   logic [RES_W-1:0] data_s1_q, data_s2_q;
   logic done_s1_q, done_s2_q, done_d_q;
   logic [7:0] div_q;
   logic [7:0] idx;
   logic wr_acc, rd_acc, done_rise, store_now;
   logic [3:0] target;
   logic [`SUM_W-1:0] sum_next;
   logic [7:0] low_byte, high_byte;
   logic [31:0] rdata_d;
   logic hit;

   // ==========================================================
   // Bus decode; access completes on the second APB cycle
   assign idx = i_paddr[9:2];
   assign wr_acc = i_psel && i_penable && o_pready && i_pwrite;
   assign rd_acc = i_psel && i_penable && o_pready && !i_pwrite;
   assign target = 4'(1 << ctl_q.average_count_sel);
   assign sum_next = sum_q + `SUM_W'(data_s2_q);
   assign done_rise = done_s2_q && !done_d_q;
   assign store_now = (state_q == sar_adc_pkg::ST_STORE) && !flag_q;

   // Justified views; unused positions are zero
   always_comb begin
      if (cfg_q.result_justify) begin
         high_byte = result_q[10:3];
         low_byte = {4'h0, result_q[2:0], 1'b0};
      end else begin
         high_byte = {5'h00, result_q[10:8]};
         low_byte = result_q[7:0];
      end
   end

   // Read mux, captured in the setup cycle
   always_comb begin
      hit = 1'b1;
      rdata_d = 32'h0000_0000;
      unique case (idx)
         `CFG_IDX: rdata_d[7:0] = {cfg_q.conv_enable, cfg_q.conv_irq_enable,
            cfg_q.result_justify, 2'b00, cfg_q.prescale};
         `LOW_IDX: rdata_d[7:0] = low_byte;
         `HIGH_IDX: rdata_d[7:0] = high_byte;
         `CTL_IDX: rdata_d[7:0] = {ctl_q.average_count_sel, ctl_q.input_select,
            2'b00, flag_q, start_q};
         `STAT_IDX: rdata_d[0] = status_q;
         `MASK_IDX: rdata_d[0] = mask_q;
         default: hit = 1'b0;
      endcase
   end

   // No wait state: answer registered in setup, held through access
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= i_psel && !i_penable;
         o_prdata <= (i_psel && !i_penable && !i_pwrite) ? rdata_d : 32'h0000_0000;
         o_pslverr <= i_psel && !i_penable && !hit;
      end
   end

   // Config and control fields; result bytes ignore writes
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_q <= sar_adc_pkg::conv_cfg_t'(`CFG_RST);
         ctl_q <= sar_adc_pkg::conv_ctl_t'(`CTL_RST >> 4);
         mask_q <= 1'(`MASK_RST);
      end else if (wr_acc) begin
         if (idx == `CFG_IDX) begin
            cfg_q.conv_enable <= i_pwdata[`CFG_EN_BIT];
            cfg_q.conv_irq_enable <= i_pwdata[`CFG_IRQ_BIT];
            cfg_q.result_justify <= i_pwdata[`CFG_JUST_BIT];
            cfg_q.prescale <= i_pwdata[`CFG_PRE_LSB +: 3];
         end
         // Averaging is not locked while running; software keeps it stable
         if (idx == `CTL_IDX) begin
            ctl_q.average_count_sel <= i_pwdata[`CTL_AVG_LSB +: 2];
            ctl_q.input_select <= i_pwdata[`CTL_SEL_LSB +: 2];
         end
         if (idx == `MASK_IDX) begin
            mask_q <= i_pwdata[0];
         end
      end
   end

   // Start bit: set by software only while conv enable is one, cleared by hardware at completion
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         start_q <= 1'b0;
      end else if (store_now) begin
         start_q <= 1'b0;
      end else if (wr_acc && idx == `CTL_IDX && i_pwdata[`CTL_START_BIT]) begin
         start_q <= cfg_q.conv_enable;
      end
   end

   // Done flag: set wins over the low-byte read clear
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flag_q <= 1'b0;
      end else if (store_now) begin
         flag_q <= 1'b1;
      end else if (rd_acc && idx == `LOW_IDX) begin
         flag_q <= 1'b0;
      end
   end

   // Sticky event status, write one to clear
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_q <= 1'b0;
      end else if (store_now) begin
         status_q <= 1'b1;
      end else if (wr_acc && idx == `STAT_IDX && i_pwdata[0]) begin
         status_q <= 1'b0;
      end
   end

   // Level interrupt, gated by mask and irq enable
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= status_q && mask_q && cfg_q.conv_irq_enable;
      end
   end

   // ==========================================================
   // Core side: synchronise done and data, derive divided clock
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         done_s1_q <= 1'b0;
         done_s2_q <= 1'b0;
         done_d_q <= 1'b0;
         data_s1_q <= '0;
         data_s2_q <= '0;
      end else begin
         done_s1_q <= i_core_done;
         done_s2_q <= done_s1_q;
         done_d_q <= done_s2_q;
         data_s1_q <= i_core_data; // Core holds data while done is high
         data_s2_q <= data_s1_q;
      end
   end

   // Half period of 2^pre system clocks gives divide by 2^(pre+1)
   // Compare is >= so lowering the prescale never waits for a counter wrap
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_q <= 8'h00;
         o_core_clk <= 1'b0;
      end else if (!cfg_q.conv_enable) begin
         div_q <= 8'h00;
         o_core_clk <= 1'b0;
      end else if (div_q >= 8'((1 << cfg_q.prescale) - 1)) begin
         div_q <= 8'h00;
         o_core_clk <= !o_core_clk;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // Enable and select follow the software fields
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_conv_enable <= 1'b0;
         o_input_select <= 2'b00;
      end else begin
         o_conv_enable <= cfg_q.conv_enable;
         o_input_select <= ctl_q.input_select;
      end
   end

   // ==========================================================
   // Sequencer: launch, collect samples, hold until flag is free
   // Single selected channel is averaged fully before the next is taken
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= sar_adc_pkg::ST_IDLE;
         o_core_start <= 1'b0;
         sum_q <= '0;
         taken_q <= 4'h0;
         result_q <= '0;
      end else begin
         o_core_start <= 1'b0;
         unique case (state_q)
            sar_adc_pkg::ST_IDLE: begin
               sum_q <= '0;
               taken_q <= 4'h0;
               if (start_q && cfg_q.conv_enable) begin
                  state_q <= sar_adc_pkg::ST_LAUNCH;
               end
            end
            sar_adc_pkg::ST_LAUNCH: begin
               o_core_start <= 1'b1;
               state_q <= sar_adc_pkg::ST_WAIT;
            end
            sar_adc_pkg::ST_WAIT: begin
               if (done_rise) begin
                  sum_q <= sum_next;
                  taken_q <= taken_q + 4'h1;
                  state_q <= (taken_q + 4'h1 == target) ? sar_adc_pkg::ST_STORE
                     : sar_adc_pkg::ST_LAUNCH;
               end
            end
            sar_adc_pkg::ST_STORE: begin
               if (!flag_q) begin
                  result_q <= RES_W'(sum_q >> ctl_q.average_count_sel);
                  state_q <= sar_adc_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   sequence low_read_s;
      rd_acc && idx == `LOW_IDX;
   endsequence

   flag_clear_a: assert property (low_read_s and !store_now |=> !flag_q)
      else $error("done flag not cleared by low byte read");
   flag_set_a: assert property (store_now |=> flag_q && !start_q)
      else $error("completion did not set flag and clear start");
   result_hold_a: assert property (flag_q && !store_now |=> $stable(result_q))
      else $error("result changed while flag set");
   irq_gate_a: assert property (!cfg_q.conv_irq_enable |=> !o_irq)
      else $error("interrupt raised while disabled");
   irq_raise_a: assert property (store_now && mask_q && cfg_q.conv_irq_enable
      |=> ##1 o_irq)
      else $error("interrupt missing after completion");
   ro_result_a: assert property (wr_acc && (idx == `LOW_IDX || idx == `HIGH_IDX)
      |=> $stable(result_q))
      else $error("write altered result");
   justify_zero_a: assert property (cfg_q.result_justify |-> low_byte[7:4] == 4'h0
      && low_byte[0] == 1'b0)
      else $error("justified low byte carries stray bits");
   lsb_zero_a: assert property (!cfg_q.result_justify |-> high_byte[7:3] == 5'h00)
      else $error("right justified high byte carries stray bits");
   avg_count_a: assert property (state_q == sar_adc_pkg::ST_STORE |-> taken_q == target)
      else $error("sample count differs from averaging setting");
   clk_div_a: assert property (cfg_q.conv_enable && cfg_q.prescale == 3'h0
      && $stable(cfg_q) ##1 $stable(cfg_q) |-> o_core_clk != $past(o_core_clk))
      else $error("divide by two clock not toggling");
endmodule

// ---- logic/sar_adc_pkg.sv ----
// Types shared by the converter control logic
package sar_adc_pkg;
   // Sequencer states, Gray coded along idle-launch-wait-store
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LAUNCH = 2'b01,
      ST_WAIT = 2'b11,
      ST_STORE = 2'b10
   } seq_state_t;
   // Software configuration as carried through the block
   typedef struct packed {
      logic conv_enable;
      logic conv_irq_enable;
      logic result_justify;
      logic [2:0] prescale;
   } conv_cfg_t;
   // Control fields
   typedef struct packed {
      logic [1:0] average_count_sel;
      logic [1:0] input_select;
   } conv_ctl_t;
endpackage

// ---- tb/adc_core_model.sv ----
// Behavioural analog converter core that answers start pulses with a sample
`timescale 1ns/100ps
module adc_core_model (
   input wire logic i_clk_sys,
   input wire logic i_start,
   input wire logic [10:0] i_level,
   output logic o_done,
   output logic [10:0] o_data
);
   logic odd_q = 1'b0;
   // Every second sample is two codes higher, so an average differs from a single sample
   initial begin
      o_done = 1'b0;
      o_data = 11'h000;
      forever begin
         @(posedge i_clk_sys);
         if (i_start === 1'b1) begin
            repeat (5) @(posedge i_clk_sys);
            o_done <= 1'b1;
            o_data <= i_level + (odd_q ? 11'h002 : 11'h000);
            odd_q <= ~odd_q;
            repeat (4) @(posedge i_clk_sys);
            o_done <= 1'b0;
            o_data <= ~o_data; // Released bus must not keep showing the sample
         end
      end
   end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`include "sar_adc_cfg.svh"
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic core_done;
   logic [10:0] core_data;
   logic conv_en;
   logic core_clk;
   logic core_start;
   logic [1:0] in_sel;
   logic irq;
   logic [10:0] lvl = 11'h5A3;
   logic [10:0] res_a;
   logic [31:0] rdat;
   logic slv;
   int par = 0;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   // ==========================================
   // Clock, design and core model
   initial begin
      forever #4 clk = ~clk;
   end
   sar_adc_control dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_core_done(core_done),
      .i_core_data(core_data), .o_conv_enable(conv_en), .o_core_clk(core_clk),
      .o_core_start(core_start), .o_input_select(in_sel), .o_irq(irq));
   adc_core_model core_u (.i_clk_sys(clk), .i_start(core_start), .i_level(lvl),
      .o_done(core_done), .o_data(core_data));
   // ==========================================
   // Comparison, bus and expectation helpers
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Request held until pready is seen high at an edge
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdat = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_flag();
      int n;
      n = 0;
      xfer(1'b0, `CTL_IDX, 8'h00);
      while (rdat[1] !== 1'b1 && n < 300) begin
         n++;
         xfer(1'b0, `CTL_IDX, 8'h00);
      end
   endtask
   // Mean of the model's alternating samples; advances the sample phase
   function automatic logic [10:0] expect_res(input int avg);
      logic [13:0] sum;
      sum = 14'h0000;
      for (int k = 0; k < (1 << avg); k++) begin
         sum = sum + 14'(lvl) + (((par + k) % 2 == 1) ? 14'h0002 : 14'h0000);
      end
      par = (par + (1 << avg)) % 2;
      return 11'(sum >> avg);
   endfunction
   function automatic logic [31:0] fmt(input logic [10:0] r, input logic j, input logic hi);
      if (j) return hi ? {24'h000000, r[10:3]} : {24'h000000, 4'h0, r[2:0], 1'b0};
      return hi ? {29'h00000000, r[10:8]} : {24'h000000, r[7:0]};
   endfunction
   task automatic read_res(input logic [10:0] r, input logic j);
      xfer(1'b0, `HIGH_IDX, 8'h00); // High byte first
      chk("result_high", rdat, fmt(r, j, 1'b1));
      xfer(1'b0, `LOW_IDX, 8'h00);
      chk("result_low", rdat, fmt(r, j, 1'b0));
   endtask
   // Full conversion; irq enable follows justify, mask is set
   task automatic do_conv(input int avg, input logic [1:0] sel, input logic j);
      logic [10:0] r;
      r = expect_res(avg);
      xfer(1'b1, `CTL_IDX, {2'(avg), sel, 4'h1}); // Averaging set while idle
      @(posedge clk); // Select output is registered one edge after the write
      chk("input_select", {30'h0, in_sel}, {30'h0, sel});
      wait_flag();
      chk("ctl_after_done", rdat, {24'h0, 2'(avg), sel, 4'h2});
      repeat (2) @(posedge clk);
      chk("irq_level", {31'h0, irq}, {31'h0, j});
      xfer(1'b1, `STAT_IDX, 8'h01);
      read_res(r, j);
      chk("irq_cleared", {31'h0, irq}, 32'h0);
      xfer(1'b0, `CTL_IDX, 8'h00);
      chk("flag_cleared", {31'h0, rdat[1]}, 32'h0);
   endtask
   task automatic prescale_check();
      int c;
      int rises;
      int last;
      int per;
      logic prev;
      for (int p = 0; p < 8; p++) begin
         xfer(1'b1, `CFG_IDX, {5'b10000, 3'(p)});
         rises = 0;
         last = 0;
         per = 0;
         prev = core_clk;
         for (c = 0; c < 1000 && rises < 3; c++) begin
            @(posedge clk);
            if (core_clk === 1'b1 && prev === 1'b0) begin
               rises++;
               if (rises == 3) per = c - last;
               last = c;
            end
            prev = core_clk;
         end
         chk("core_clk_period", 32'(per), 32'(2 << p));
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ==========================================
   // Hang guard, well above the expected run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         conclude();
      end
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      xfer(1'b0, `CFG_IDX, 8'h00);
      chk("config_reset", rdat, 32'h0);
      xfer(1'b0, `CTL_IDX, 8'h00);
      chk("ctl_reset", rdat, 32'h0);
      xfer(1'b0, 8'h10, 8'h00);
      chk("unmapped_err", {31'h0, slv}, 32'h1);
      xfer(1'b1, `CTL_IDX, 8'h01);
      xfer(1'b0, `CTL_IDX, 8'h00);
      chk("start_while_off", rdat, 32'h0);
      chk("core_clk_idle", {31'h0, core_clk}, 32'h0);
      $display("test reset_and_refusal done");
      xfer(1'b1, `MASK_IDX, 8'h01);
      xfer(1'b1, `CFG_IDX, 8'h80);
      repeat (2500) @(posedge clk); // Bias settling time after enable
      chk("conv_enable", {31'h0, conv_en}, 32'h1);
      for (int j = 0; j < 2; j++) begin
         xfer(1'b1, `CFG_IDX, {1'b1, 1'(j), 1'(j), 5'h00});
         for (int a = 0; a < 4; a++) do_conv(a, 2'(a), 1'(j));
      end
      $display("test formats_and_averaging done");
      res_a = expect_res(0);
      xfer(1'b1, `CTL_IDX, 8'h01);
      wait_flag();
      lvl = 11'h1C6;
      xfer(1'b1, `CTL_IDX, 8'h01);
      for (int n = 0; n < 200 && core_done !== 1'b1; n++) @(posedge clk);
      repeat (8) @(posedge clk);
      xfer(1'b1, `HIGH_IDX, 8'hFF);
      xfer(1'b1, `LOW_IDX, 8'hFF);
      read_res(res_a, 1'b1); // Held result survives
      wait_flag();
      read_res(expect_res(0), 1'b1);
      $display("test overwrite_guard done");
      prescale_check();
      $display("test prescale done");
      conclude();
   end
endmodule
